// ### tb/sdi_link_checker.sv
// assertion checker for the controller-memory link
// assumes the bench instantiates it beside the joining interface
`timescale 1ns/1ps
`include "sdi_params.svh"
module sdi_link_checker #(
   parameter int PWRUP_CYC = `SDI_PWRUP_CYC    // controller wait length
) (
   input wire logic                  clock,        // system clock
   input wire logic                  arst_n,       // async reset, low
   input wire logic [3:0]            cmd,          // command pins
   input wire logic                  bankSelectLo, // bank bit 0
   input wire logic                  bankSelectHi, // bank bit 1
   input wire logic [`SDI_ROW_W-1:0] addrIn,       // address pins
   input wire logic                  ctlDataOe,    // controller drives
   input wire logic                  memDataOe     // memory drives
);
   // ==========================================
   // helper state
   int   cycCnt;  // edges since reset
   int   refCnt;  // refreshes seen
   logic lmrSeen; // mode loaded once
   logic busy;    // first real command seen
   logic quiet;   // nop or inhibit
   assign quiet = cmd inside {sdi_pkg::CMD_NOP, sdi_pkg::CMD_INHIBIT};
   // counters saturate: cycCnt at the wait length, refCnt at three
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cycCnt  <= 0;
         refCnt  <= 0;
         lmrSeen <= 1'b0;
         busy    <= 1'b0;
      end else begin
         cycCnt  <= (cycCnt < PWRUP_CYC) ? cycCnt + 1 : cycCnt;
         refCnt  <= (cmd == sdi_pkg::CMD_REF && refCnt < 3) ? refCnt + 1 : refCnt;
         lmrSeen <= lmrSeen | (cmd == sdi_pkg::CMD_LMR);
         busy    <= busy | !quiet;
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // reset cycles count towards the wait, hence one short
   a_wait_quiet: assert property (cycCnt < PWRUP_CYC - 1 |-> quiet)
      else $error("command issued during power-up wait");
   a_first_precharge: assert property (!busy && !quiet |-> cmd == sdi_pkg::CMD_PRE && addrIn[10])
      else $error("first command is not precharge all");
   a_refresh_first: assert property (cmd == sdi_pkg::CMD_LMR |-> refCnt >= 2)
      else $error("mode load before two refreshes");
   a_mode_before_use: assert property (cmd == sdi_pkg::CMD_ACT |-> lmrSeen)
      else $error("activate before mode load");
   a_access_opened: assert property (cmd inside {sdi_pkg::CMD_RD, sdi_pkg::CMD_WR} |->
      $past(cmd, 2) == sdi_pkg::CMD_ACT && $past(bankSelectLo, 2) == bankSelectLo
      && $past(bankSelectHi, 2) == bankSelectHi)
      else $error("access without activate of same bank");
   a_column_flags: assert property (cmd inside {sdi_pkg::CMD_RD, sdi_pkg::CMD_WR} |->
      addrIn[11:8] == 4'h4)
      else $error("access address high bits wrong");
   a_read_turn: assert property (cmd == sdi_pkg::CMD_RD |=> memDataOe && !ctlDataOe)
      else $error("memory not driving after read");
   a_write_drive: assert property (cmd == sdi_pkg::CMD_WR |-> ctlDataOe && !memDataOe)
      else $error("controller not driving write data");
   a_mode_bank: assert property (cmd == sdi_pkg::CMD_LMR |-> !bankSelectLo)
      else $error("mode load with bank bit 0 set");
endmodule

// ### tb/sdram_init_and_addressing_tb.sv
// bench: controller and memory joined, plus a lone memory driven by hand
// assumes design files and the checker are compiled first
`timescale 1ns/1ps
`include "sdi_params.svh"
module sdram_init_and_addressing_tb;
   localparam int          PWR   = 20;      // shortened wait
   localparam logic [11:0] MODEW = 12'h032; // mode opcode
   localparam logic [11:0] EXTW  = 12'h005; // extended opcode
   // ==========================================
   // signals
   logic        clock = 1'b0, arst_n = 1'b0, arstBad_n = 1'b0; // clock, resets
   logic        reqValid = 1'b0, reqWrite = 1'b0; // request strobe, kind
   logic [1:0]  reqBank = 2'h0;                  // bank
   logic [11:0] reqRow = 12'h000;                // row
   logic [7:0]  reqCol = 8'h00;                  // column
   logic [15:0] reqData = 16'h0000, rspData;     // data both ways
   logic        ready, rspValid, modeLoaded, seqError, loadedBad, errBad; // status
   logic [3:0]  openBanks, openBad;              // open rows
   logic [11:0] modeReg, extModeReg, modeBad, extBad; // mode registers
   logic [1:0]  refreshCount, refBad;            // refreshes
   int          errors = 0, tests_run = 0, nopCnt = 0; // tallies
   logic [17:0] initSeq[$];                      // first real commands
   logic [17:0] lastAct, lastAcc;                // last activate, access
   sdi_link_if sdi_link_if_i ();
   sdi_link_if sdi_link_bad_if_i ();
   wire  [17:0] pins = {sdi_link_if_i.cmd, sdi_link_if_i.bankSelectHi,
                        sdi_link_if_i.bankSelectLo, sdi_link_if_i.addrIn};
   sdi_controller #(.PWRUP_CYC(PWR), .MODE_WORD(MODEW), .EXT_WORD(EXTW)) sdi_controller_i (
      .clock(clock), .arst_n(arst_n), .link(sdi_link_if_i.ctl), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqBank(reqBank), .reqRow(reqRow), .reqCol(reqCol),
      .reqData(reqData), .ready(ready), .rspValid(rspValid), .rspData(rspData));
   sdi_memory sdi_memory_i (.clock(clock), .arst_n(arst_n), .link(sdi_link_if_i.mem),
      .openBanks(openBanks), .modeReg(modeReg), .extModeReg(extModeReg),
      .modeLoaded(modeLoaded), .refreshCount(refreshCount), .seqError(seqError));
   // lone memory: the bench plays a careless controller
   sdi_memory sdi_memory_bad_i (.clock(clock), .arst_n(arstBad_n), .link(sdi_link_bad_if_i.mem),
      .openBanks(openBad), .modeReg(modeBad), .extModeReg(extBad),
      .modeLoaded(loadedBad), .refreshCount(refBad), .seqError(errBad));
   sdi_link_checker #(.PWRUP_CYC(PWR)) sdi_link_checker_i (.clock(clock), .arst_n(arst_n),
      .cmd(sdi_link_if_i.cmd), .bankSelectLo(sdi_link_if_i.bankSelectLo),
      .bankSelectHi(sdi_link_if_i.bankSelectHi), .addrIn(sdi_link_if_i.addrIn),
      .ctlDataOe(sdi_link_if_i.ctlDataOe), .memDataOe(sdi_link_if_i.memDataOe));
   always #5 clock = ~clock;
   // ==========================================
   // wire monitor: wait length, init order, last addresses
   always @(posedge clock) begin
      if (arst_n && pins[17:14] inside {sdi_pkg::CMD_NOP, sdi_pkg::CMD_INHIBIT}) begin
         if (initSeq.size() == 0) nopCnt++;
      end else if (arst_n) begin
         if (initSeq.size() < 5) initSeq.push_back(pins);
         if (pins[17:14] == sdi_pkg::CMD_ACT) lastAct <= pins;
         if (pins[17:14] inside {sdi_pkg::CMD_RD, sdi_pkg::CMD_WR}) lastAcc <= pins;
      end
   end
   // ==========================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // bounded wait; a hang ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 500) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 500) begin
         errors++;
         $display("Error ready expected 1 seen timeout");
         finish_test();
      end
   endtask
   // one user access; read data returned, wire addresses judged
   task automatic access(input logic w, input logic [1:0] b, input logic [11:0] row,
                         input logic [7:0] col, input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      wait_ready();
      @(posedge clock);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqBank  <= b;
      reqRow   <= row;
      reqCol   <= col;
      reqData  <= d;
      @(posedge clock);
      reqValid <= 1'b0;
      #1;
      if (!w) begin
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (rspValid !== 1'b1 && n < 10);
         check("read latency", n, 4);
         q = rspData;
      end
      wait_ready();
      // a write's access command reaches the monitor one edge after ready
      @(posedge clock);
      #1;
      check("act pins", lastAct, {sdi_pkg::CMD_ACT, b, row});
      check("access pins", lastAcc, {w ? sdi_pkg::CMD_WR : sdi_pkg::CMD_RD, b, 4'h4, col});
   endtask
   // one command on the lone memory, then nop
   task automatic bcmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      @(posedge clock);
      sdi_link_bad_if_i.cmd          <= c;
      sdi_link_bad_if_i.bankSelectHi <= b[1];
      sdi_link_bad_if_i.bankSelectLo <= b[0];
      sdi_link_bad_if_i.addrIn       <= a;
      @(posedge clock);
      sdi_link_bad_if_i.cmd <= sdi_pkg::CMD_NOP;
      #1;
   endtask
   // ==========================================
   // scenarios
   task automatic test_init();
      wait_ready();
      check("wait nops", nopCnt >= PWR - 1, 1);
      check("first cmd", {initSeq[0][17:14], initSeq[0][10]}, {sdi_pkg::CMD_PRE, 1'b1});
      check("refresh 1", initSeq[1][17:14], sdi_pkg::CMD_REF);
      check("refresh 2", initSeq[2][17:14], sdi_pkg::CMD_REF);
      check("mode load", initSeq[3], {sdi_pkg::CMD_LMR, 2'h0, MODEW});
      check("ext load", initSeq[4], {sdi_pkg::CMD_LMR, 2'h2, EXTW});
      check("mode reg", {modeReg, extModeReg, modeLoaded}, {MODEW, EXTW, 1'b1});
      check("ref count", refreshCount, 2'h2);
      $display("test init done");
   endtask
   // all banks, boundary rows and columns, then an overwrite
   task automatic test_access();
      logic [15:0] q;
      for (int b = 0; b < 4; b++)
         access(1'b1, b[1:0], 12'h555 * b[11:0], 8'hff - 8'h55 * b[7:0], 16'hc3a0 + b[15:0], q);
      access(1'b1, 2'h1, 12'h555, 8'haa, 16'h5a5a, q);
      for (int b = 0; b < 4; b++) begin
         access(1'b0, b[1:0], 12'h555 * b[11:0], 8'hff - 8'h55 * b[7:0], 16'h0000, q);
         check("read data", q, (b == 1) ? 16'h5a5a : 16'hc3a0 + b[15:0]);
      end
      check("banks closed", {openBanks, seqError}, 5'h00);
      $display("test access done");
   endtask
   // bank tracking, precharge forms, mode select, misuse flags
   task automatic test_lone();
      bcmd(sdi_pkg::CMD_ACT, 2'h1, 12'h123);
      bcmd(sdi_pkg::CMD_ACT, 2'h2, 12'hfff);
      check("open two", openBad, 4'h6);
      bcmd(sdi_pkg::CMD_PRE, 2'h1, 12'h000);
      check("pre one", openBad, 4'h4);
      bcmd(sdi_pkg::CMD_ACT, 2'h3, 12'h000);
      bcmd(sdi_pkg::CMD_PRE, 2'h0, 12'h400);
      check("pre all", openBad, 4'h0);
      bcmd(sdi_pkg::CMD_LMR, 2'h2, 12'h3c5);
      bcmd(sdi_pkg::CMD_LMR, 2'h0, 12'h0a6);
      check("lone modes", {modeBad, extBad, errBad}, {12'h0a6, 12'h3c5, 1'b0});
      bcmd(sdi_pkg::CMD_RD, 2'h1, 12'h400);
      check("closed read", errBad, 1'b1);
      repeat (4) bcmd(sdi_pkg::CMD_REF, 2'h0, 12'h000);
      check("lone refresh", refBad, 2'h3);
      arstBad_n <= 1'b0;
      @(posedge clock);
      arstBad_n <= 1'b1;
      #1;
      check("lone reset", {modeBad, extBad, loadedBad, refBad, openBad, errBad}, 32'h0);
      bcmd(sdi_pkg::CMD_ACT, 2'h0, 12'h010);
      bcmd(sdi_pkg::CMD_LMR, 2'h0, 12'h000);
      check("load while open", {errBad, loadedBad, openBad}, 6'h31);
      $display("test lone done");
   endtask
   // ==========================================
   // main sequence
   initial begin
      sdi_link_bad_if_i.cmd          = sdi_pkg::CMD_NOP;
      sdi_link_bad_if_i.bankSelectHi = 1'b0;
      sdi_link_bad_if_i.bankSelectLo = 1'b0;
      sdi_link_bad_if_i.addrIn       = 12'h000;
      sdi_link_bad_if_i.ctlDataOut   = 16'h0000;
      sdi_link_bad_if_i.ctlDataOe    = 1'b0;
      repeat (4) @(posedge clock);
      arst_n    <= 1'b1;
      arstBad_n <= 1'b1;
      test_init();
      test_access();
      test_lone();
      finish_test();
   end
endmodule

// ### verilog/sdi_controller.sv
// controller end: power-up sequence, then one user access at a time
// assumes memory answers reads one cycle after the read command
`timescale 1ns/1ps
`include "sdi_params.svh"
module sdi_controller #(
   parameter int PWRUP_CYC = `SDI_PWRUP_CYC,  // 100 us wait
   parameter logic [`SDI_ROW_W-1:0] MODE_WORD = 12'h000, // opcode to load
   parameter logic [`SDI_ROW_W-1:0] EXT_WORD  = 12'h000  // extended opcode
) (
   input  wire logic clock,                   // system clock
   input  wire logic arst_n,                  // async reset, low
   sdi_link_if.ctl   link,                    // pins to the memory
   input  wire logic reqValid,                // user access request
   input  wire logic reqWrite,                // 1 write, 0 read
   input  wire logic [1:0] reqBank,           // bank
   input  wire logic [`SDI_ROW_W-1:0] reqRow, // row
   input  wire logic [`SDI_COL_W-1:0] reqCol, // column
   input  wire logic [`SDI_DATA_W-1:0] reqData, // write data
   output logic      ready,                   // init done and idle
   output logic      rspValid,                // read data valid pulse
   output logic [`SDI_DATA_W-1:0] rspData     // read data
);
   // =====================================================
   typedef enum logic [2:0] {A_IDLE, A_ACT, A_RW, A_WAIT, A_RSP} sdi_acc_t;
   sdi_pkg::sdi_init_t st_r, st_nxt;
   sdi_acc_t           ac_r, ac_nxt;
   logic [15:0]        cnt_r, cnt_nxt;        // wait counter
   logic [1:0]         refs_r, refs_nxt;
   logic               extDone_r, extDone_nxt;
   logic [3:0]         cmd_r, cmd_nxt;
   logic [1:0]         ba_r, ba_nxt;
   logic [`SDI_ROW_W-1:0] ad_r, ad_nxt;
   logic [`SDI_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic               oe_r, oe_nxt, rv_r, rv_nxt, we_r, we_nxt;
   logic [`SDI_COL_W-1:0] col_r, col_nxt;

   // =====================================================
   // init and access sequencer, next state
   always_comb begin
      st_nxt = st_r; ac_nxt = ac_r; cnt_nxt = cnt_r; refs_nxt = refs_r;
      extDone_nxt = extDone_r;
      cmd_nxt = sdi_pkg::CMD_NOP;
      ba_nxt = ba_r; ad_nxt = ad_r; wd_nxt = wd_r; rd_nxt = rd_r;
      oe_nxt = 1'b0; rv_nxt = 1'b0; we_nxt = we_r; col_nxt = col_r;
      case (st_r)
         sdi_pkg::IS_WAIT: begin
            if (cnt_r == 16'(PWRUP_CYC - 1)) begin
               st_nxt = sdi_pkg::IS_PRE;
            end else begin
               cnt_nxt = cnt_r + 16'h1;
            end
         end
         sdi_pkg::IS_PRE: begin
            cmd_nxt = sdi_pkg::CMD_PRE;
            ad_nxt  = '0;
            ad_nxt[`SDI_AP_BIT] = 1'b1;
            cnt_nxt = 16'(`SDI_TRP_CYC);
            st_nxt  = sdi_pkg::IS_TRP;
         end
         sdi_pkg::IS_TRP, sdi_pkg::IS_TRFC, sdi_pkg::IS_TMRD: begin
            if (cnt_r != 16'h0) begin
               cnt_nxt = cnt_r - 16'h1;
            end else if (st_r == sdi_pkg::IS_TMRD) begin
               // bank field still names the register just loaded: bank 2 is the last one
               st_nxt = (ba_r == 2'h2) ? sdi_pkg::IS_READY : sdi_pkg::IS_LMR;
            end else if (st_r == sdi_pkg::IS_TRFC && refs_r == 2'(`SDI_REFRESHES)) begin
               st_nxt = sdi_pkg::IS_LMR;
            end else begin
               st_nxt = sdi_pkg::IS_REF;
            end
         end
         sdi_pkg::IS_REF: begin
            cmd_nxt  = sdi_pkg::CMD_REF;
            refs_nxt = refs_r + 2'h1;
            cnt_nxt  = 16'(`SDI_TRFC_CYC);
            st_nxt   = sdi_pkg::IS_TRFC;
         end
         sdi_pkg::IS_LMR: begin
            cmd_nxt = sdi_pkg::CMD_LMR;
            // first the ordinary register, then the extended one
            ba_nxt  = extDone_r ? 2'h2 : 2'h0;
            ad_nxt  = extDone_r ? EXT_WORD : MODE_WORD;
            extDone_nxt = 1'b1;
            cnt_nxt = 16'(`SDI_TMRD_CYC);
            st_nxt  = sdi_pkg::IS_TMRD;
         end
         sdi_pkg::IS_READY: begin
            case (ac_r)
               A_IDLE: begin
                  if (reqValid) begin
                     cmd_nxt = sdi_pkg::CMD_ACT;
                     ba_nxt  = reqBank;
                     ad_nxt  = reqRow;
                     col_nxt = reqCol;
                     we_nxt  = reqWrite;
                     wd_nxt  = reqData;
                     ac_nxt  = A_ACT;
                  end
               end
               A_ACT: ac_nxt = A_RW;                 // one nop for row delay
               A_RW: begin
                  cmd_nxt = we_r ? sdi_pkg::CMD_WR : sdi_pkg::CMD_RD;
                  ad_nxt  = {4'h4, col_r};
                  oe_nxt  = we_r;
                  ac_nxt  = we_r ? A_IDLE : A_WAIT;
               end
               A_WAIT: ac_nxt = A_RSP;
               A_RSP: begin
                  rd_nxt = link.dataIo;
                  rv_nxt = 1'b1;
                  ac_nxt = A_IDLE;
               end
               default: ac_nxt = A_IDLE;
            endcase
         end
         default: st_nxt = sdi_pkg::IS_WAIT;
      endcase
   end

   // =====================================================
   // registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= sdi_pkg::IS_WAIT; ac_r <= A_IDLE; cnt_r <= '0; refs_r <= '0;
         extDone_r <= 1'b0; cmd_r <= sdi_pkg::CMD_INHIBIT; ba_r <= '0; ad_r <= '0;
         wd_r <= '0; rd_r <= '0; oe_r <= 1'b0; rv_r <= 1'b0; we_r <= 1'b0; col_r <= '0;
      end else begin
         st_r <= st_nxt; ac_r <= ac_nxt; cnt_r <= cnt_nxt; refs_r <= refs_nxt;
         extDone_r <= extDone_nxt; cmd_r <= cmd_nxt; ba_r <= ba_nxt; ad_r <= ad_nxt;
         wd_r <= wd_nxt; rd_r <= rd_nxt; oe_r <= oe_nxt; rv_r <= rv_nxt; we_r <= we_nxt;
         col_r <= col_nxt;
      end
   end

   // =====================================================
   // pins and user outputs from flops
   assign link.cmd          = cmd_r;
   assign link.bankSelectLo = ba_r[0];
   assign link.bankSelectHi = ba_r[1];
   assign link.addrIn       = ad_r;
   assign link.ctlDataOut   = wd_r;
   assign link.ctlDataOe    = oe_r;
   assign rspValid          = rv_r;
   assign rspData           = rd_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= (st_nxt == sdi_pkg::IS_READY) && (ac_nxt == A_IDLE);
      end
   end
endmodule

// ### verilog/sdi_link_if.sv
// pin bundle between controller and memory
// assumes one shared clock; the data wire is resolved here
`timescale 1ns/1ps
`include "sdi_params.svh"
interface sdi_link_if;
   // =====================================================
   // pins
   logic [3:0]             cmd;         // cs,ras,cas,we
   logic                   bankSelectLo; // bank bit 0
   logic                   bankSelectHi; // bank bit 1
   logic [`SDI_ROW_W-1:0]  addrIn;      // address inputs
   logic [`SDI_DATA_W-1:0] ctlDataOut;  // controller drive
   logic                   ctlDataOe;   // controller drives
   logic [`SDI_DATA_W-1:0] memDataOut;  // memory drive
   logic                   memDataOe;   // memory drives
   logic [`SDI_DATA_W-1:0] dataIo;      // resolved bus
   // memory drive wins; both driving is a bus fight
   assign dataIo = memDataOe ? memDataOut : (ctlDataOe ? ctlDataOut : '0);
   modport ctl (output cmd, bankSelectLo, bankSelectHi, addrIn, ctlDataOut, ctlDataOe,
                input dataIo);
   modport mem (input cmd, bankSelectLo, bankSelectHi, addrIn, ctlDataOut, ctlDataOe,
                output memDataOut, memDataOe, input dataIo);
endinterface

// ### verilog/sdi_memory.sv
// device end: command decode, bank and row state, mode registers, storage
// assumes the controller keeps init order and timing; small array by default
//
// What this block does
// - sample every input on rising clock
// - four banks, 4096x256 words, 16 bits; only the low ROW_BITS row bits are stored, so 16 rows per bank by default
// - access opens a row before read/write
// - bank select names the target bank
// - bank select picks mode or extended
// - activate captures twelve row bits
// - read/write take eight column bits
// - bit ten requests auto precharge
// - precharge bit ten high means all
// - address carries the mode opcode
// - controller waits 100 us first
// - nop or inhibit during the wait
// - precharge all banks after wait
// - two refreshes before mode load
// - mode loaded before operational commands
// - mode load only when idle, tmrd
`timescale 1ns/1ps
`include "sdi_params.svh"
module sdi_memory #(
   parameter int ROW_BITS = 4               // low row address bits actually stored
) (
   input  wire logic clock,                 // system clock
   input  wire logic arst_n,                // async reset, low
   sdi_link_if.mem   link,                  // pins to the controller
   output logic [3:0] openBanks,            // bank has an open row
   output logic [`SDI_ROW_W-1:0] modeReg,   // mode register
   output logic [`SDI_ROW_W-1:0] extModeReg,// extended mode register
   output logic      modeLoaded,            // mode written since reset
   output logic [1:0] refreshCount,         // refreshes seen, saturating
   output logic      seqError               // misuse: closed-bank or pre-mode access, load with rows open
);
   // =====================================================
   // storage is kept small: only ROW_BITS low row bits address the array
   localparam int DEPTH = 4 * (1 << ROW_BITS) * `SDI_COLS;
   localparam int AW    = 2 + ROW_BITS + `SDI_COL_W;
   // trade-off: a full array would be far too many flops for simulation;
   // rows that differ only in their high bits alias onto the same words
   logic [`SDI_DATA_W-1:0] mem_r [DEPTH];
   logic [`SDI_ROW_W-1:0]  rowOf_r [4];     // open row per bank
   logic [3:0]             open_r, open_nxt;
   logic [3:0]             apPend_r, apPend_nxt; // auto precharge pending
   logic [`SDI_ROW_W-1:0]  mode_r, mode_nxt, ext_r, ext_nxt;
   logic                   loaded_r, loaded_nxt;
   logic [1:0]             refCnt_r, refCnt_nxt;
   logic                   err_r, err_nxt;
   logic [`SDI_DATA_W-1:0] rdData_r, rdData_nxt;
   logic                   rdOe_r, rdOe_nxt;
   logic [1:0]             bank;
   logic [AW-1:0]          wIdx;

   // =====================================================
   // address of a column access in the open row
   function automatic logic [AW-1:0] idxOf(input logic [1:0] b, input logic [`SDI_ROW_W-1:0] r,
                                           input logic [`SDI_ROW_W-1:0] a);
      idxOf = {b, r[ROW_BITS-1:0], a[`SDI_COL_W-1:0]};
   endfunction

   assign bank = {link.bankSelectHi, link.bankSelectLo};
   assign wIdx = idxOf(bank, rowOf_r[bank], link.addrIn);

   // =====================================================
   // command decode, next state
   // one decoder serves every command; the bank field is shared by
   // activate, access and precharge, so it is decoded once above
   // limitation: every access is a single beat and the mode fields are
   // stored but not acted on, so a controller expecting bursts reads short
   // misuse is flagged in seqError so a test can see it; only a write to a closed bank is dropped
   // the error flag is sticky rather than a pulse: a late look still sees it
   always_comb begin
      open_nxt   = open_r;
      apPend_nxt = '0;
      mode_nxt   = mode_r;
      ext_nxt    = ext_r;
      loaded_nxt = loaded_r;
      refCnt_nxt = refCnt_r;
      err_nxt    = err_r;
      rdData_nxt = rdData_r;
      rdOe_nxt   = 1'b0;
      // auto precharge closes the bank one cycle after its single-beat access
      open_nxt   = open_r & ~apPend_r;
      case (sdi_pkg::sdi_cmd_t'(link.cmd))
         sdi_pkg::CMD_ACT: begin
            open_nxt[bank] = 1'b1;
         end
         sdi_pkg::CMD_RD, sdi_pkg::CMD_WR: begin
            if (!open_r[bank] || !loaded_r) begin
               err_nxt = 1'b1;
            end
            if (link.cmd == sdi_pkg::CMD_RD) begin
               rdData_nxt = mem_r[wIdx];
               rdOe_nxt   = 1'b1;
            end
            apPend_nxt[bank] = link.addrIn[`SDI_AP_BIT];
         end
         sdi_pkg::CMD_PRE: begin
            if (link.addrIn[`SDI_AP_BIT]) begin
               open_nxt = '0;
            end else begin
               open_nxt[bank] = 1'b0;
            end
         end
         sdi_pkg::CMD_REF: begin
            if (refCnt_r != 2'h3) begin
               refCnt_nxt = refCnt_r + 2'h1;
            end
         end
         sdi_pkg::CMD_LMR: begin
            if (open_r != '0) begin
               err_nxt = 1'b1;
            end
            if (link.bankSelectHi) begin
               ext_nxt = link.addrIn;
            end else begin
               mode_nxt   = link.addrIn;
               loaded_nxt = 1'b1;
            end
         end
         default: begin
            // nop, inhibit, burst stop: no state change
         end
      endcase
   end

   // =====================================================
   // registers, all sampled on the rising edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         open_r   <= '0;
         apPend_r <= '0;
         mode_r   <= `SDI_MODE_RST;
         ext_r    <= `SDI_MODE_RST;
         loaded_r <= 1'b0;
         refCnt_r <= 2'h0;
         err_r    <= 1'b0;
         rdData_r <= '0;
         rdOe_r   <= 1'b0;
      end else begin
         open_r   <= open_nxt;
         apPend_r <= apPend_nxt;
         mode_r   <= mode_nxt;
         ext_r    <= ext_nxt;
         loaded_r <= loaded_nxt;
         refCnt_r <= refCnt_nxt;
         err_r    <= err_nxt;
         rdData_r <= rdData_nxt;
         rdOe_r   <= rdOe_nxt;
      end
   end

   // =====================================================
   // row latch and array write; no reset, contents are undefined anyway
   // an access before any activate reads an unknown row, but is flagged
   // as an access to a closed bank, so the missing reset costs nothing
   always_ff @(posedge clock) begin
      if (link.cmd == sdi_pkg::CMD_ACT) begin
         rowOf_r[bank] <= link.addrIn;
      end
      if (link.cmd == sdi_pkg::CMD_WR && open_r[bank]) begin
         mem_r[wIdx] <= link.dataIo;
      end
   end

   // =====================================================
   // outputs, straight from flops; read data one cycle after the command
   assign link.memDataOut = rdData_r;
   assign link.memDataOe  = rdOe_r;
   assign openBanks       = open_r;
   assign modeReg         = mode_r;
   assign extModeReg      = ext_r;
   assign modeLoaded      = loaded_r;
   assign refreshCount    = refCnt_r;
   assign seqError        = err_r;
endmodule

// ### verilog/sdi_params.svh
// constants for the sdram init and addressing link
// assumes a 100 MHz clock on both ends
`ifndef SDI_PARAMS_SVH
`define SDI_PARAMS_SVH
// =====================================================
// geometry
`define SDI_ROW_W        12
`define SDI_COL_W        8
`define SDI_BANK_W       2
`define SDI_DATA_W       16
`define SDI_ROWS         4096
`define SDI_COLS         256
// =====================================================
// field positions on the address inputs
`define SDI_AP_BIT       10
// =====================================================
// timing
`define SDI_CLK_PERIOD_NS 10
`define SDI_PWRUP_US      100
`define SDI_PWRUP_CYC     ((`SDI_PWRUP_US * 1000 + `SDI_CLK_PERIOD_NS - 1) / `SDI_CLK_PERIOD_NS)
`define SDI_TRP_CYC       2
`define SDI_TRFC_CYC      8
`define SDI_TMRD_CYC      2
`define SDI_REFRESHES     2
// =====================================================
// reset values
`define SDI_MODE_RST      12'h000
`endif

// ### verilog/sdi_pkg.sv
// types shared by both ends of the sdram link
// assumes sdi_params.svh holds the numbers
package sdi_pkg;
   // =====================================================
   // command encoding {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_INHIBIT = 4'h8,
      CMD_LMR     = 4'h0,
      CMD_REF     = 4'h1,
      CMD_PRE     = 4'h2,
      CMD_ACT     = 4'h3,
      CMD_WR      = 4'h4,
      CMD_RD      = 4'h5,
      CMD_BST     = 4'h6,
      CMD_NOP     = 4'h7
   } sdi_cmd_t;
   // controller init sequence
   typedef enum logic [2:0] {
      IS_WAIT, IS_PRE, IS_TRP, IS_REF, IS_TRFC, IS_LMR, IS_TMRD, IS_READY
   } sdi_init_t;
endpackage
